// File: src/dsm_pkg.sv
`default_nettype none
package dsm_pkg;
    // ------------------------------------------------------------------
    // link lanes and pixel packing
    // ------------------------------------------------------------------
    localparam int LANE_BITS = 7;
    localparam int NUM_LANES = 8;
    localparam int LANES_6BIT = 3;
    localparam int LANES_8BIT = 4;
    localparam int PIX2_LANE_BASE = 4;
    localparam int NUM_STREAMS = 3;
    localparam int HS_OFS = 0;
    localparam int VS_OFS = 1;
    localparam int DE_OFS = 2;
    localparam int RETRAIN_CYC = 64;

    typedef enum logic [1:0] {
        SW_IMMEDIATE,
        SW_VS_START,
        SW_VS_END
    } dsm_mode_e;

    typedef logic [NUM_LANES*LANE_BITS-1:0] dsm_lanes_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic hs;
        logic vs;
        logic de;
    } dsm_pix_s;

    typedef struct packed {
        logic ovr;
        logic sel;
    } dsm_ctrl_s;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam int CTRL_OVR_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_SEL_BIT = 0;
    localparam int STAT_ALIGN_BIT = 1;
    localparam int STAT_PEND_BIT = 2;
    localparam int CFG_PPC2_BIT = 0;
    localparam int CFG_DEPTH8_BIT = 1;
    localparam int CFG_PLL2_BIT = 2;
    localparam int CFG_MODE_LSB = 3;
    localparam int CFG_VSNEW_BIT = 5;
    localparam int CFG_CE_BIT = 6;
    localparam int CFG_RGB_LSB = 7;
endpackage
`default_nettype wire

// File: src/dsm_mux.sv
`timescale 1ns/100ps
`default_nettype none
module dsm_mux #(
    parameter int PIX_PER_CLK = 1,
    parameter int COLOR_DEPTH = 8,
    parameter int NUM_PLLS = 2,
    parameter dsm_pkg::dsm_mode_e SWITCH_MODE = dsm_pkg::SW_VS_START,
    parameter bit VS_NEW = 1'b1,
    parameter bit HAS_CE = 1'b0,
    parameter logic [2:0] RGB_EN = 3'h0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pix_clk,
    input wire dsm_pkg::dsm_lanes_t lanes_a,
    input wire dsm_pkg::dsm_lanes_t lanes_b,
    input wire logic mux_sel,
    input wire logic ce,
    output dsm_pkg::dsm_lanes_t lanes_c,
    output logic sel_out,
    output logic aligned,
    output dsm_pkg::dsm_pix_s par_pix [dsm_pkg::NUM_STREAMS][2]
);
    // ------------------------------------------------------------------
    // build options
    // ------------------------------------------------------------------
    localparam bit PPC2 = (PIX_PER_CLK == 2);
    localparam bit DEPTH8 = (COLOR_DEPTH == 8);
    localparam bit TWO_PLLS = (NUM_PLLS == 2);
    localparam int LANES_PER = DEPTH8 ? dsm_pkg::LANES_8BIT
                                      : dsm_pkg::LANES_6BIT;
    localparam int CW = $clog2(dsm_pkg::RETRAIN_CYC + 1);

    // lanes carried for this build, pixel two starting at a fixed base
    function automatic dsm_pkg::dsm_lanes_t lane_mask();
        dsm_pkg::dsm_lanes_t m;
        m = '0;
        for (int i = 0; i < dsm_pkg::NUM_LANES; i++) begin
            if (i < LANES_PER || (PPC2 && i >= dsm_pkg::PIX2_LANE_BASE &&
                i < dsm_pkg::PIX2_LANE_BASE + LANES_PER)) begin
                m[i*dsm_pkg::LANE_BITS +: dsm_pkg::LANE_BITS] = '1;
            end
        end
        return m;
    endfunction

    // colour fields packed low, timing bits right above them
    function automatic dsm_pkg::dsm_pix_s decode_pix(
        input dsm_pkg::dsm_lanes_t ln,
        input int base
    );
        logic [27:0] w;
        int d;
        dsm_pkg::dsm_pix_s p;
        w = 28'(ln >> (base * dsm_pkg::LANE_BITS));
        d = COLOR_DEPTH;
        p = '0;
        for (int i = 0; i < 8; i++) begin
            if (i < d) begin
                p.b[i] = w[i];
                p.g[i] = w[d+i];
                p.r[i] = w[2*d+i];
            end
        end
        p.hs = w[3*d+dsm_pkg::HS_OFS];
        p.vs = w[3*d+dsm_pkg::VS_OFS];
        p.de = w[3*d+dsm_pkg::DE_OFS];
        return p;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return a == dsm_pkg::ADDR_CTRL || a == dsm_pkg::ADDR_STATUS ||
               a == dsm_pkg::ADDR_CONFIG;
    endfunction

    // ------------------------------------------------------------------
    // link domain reset and input synchronisers
    // ------------------------------------------------------------------
    logic prst_meta_q;
    logic prst_n_q;
    dsm_pkg::dsm_ctrl_s ctrl_q;
    logic [3:0] in_meta_q;
    logic [3:0] in_sync_q;

    // assert at once, release on a link edge to avoid a torn recovery
    always_ff @(posedge pix_clk or negedge reset_n) begin
        if (!reset_n) begin
            prst_meta_q <= 1'b0;
            prst_n_q <= 1'b0;
        end else begin
            prst_meta_q <= 1'b1;
            prst_n_q <= prst_meta_q;
        end
    end

    always_ff @(posedge pix_clk or negedge prst_n_q) begin
        if (!prst_n_q) begin
            in_meta_q <= 4'h0;
            in_sync_q <= 4'h0;
        end else begin
            in_meta_q <= {mux_sel, ce, ctrl_q.ovr, ctrl_q.sel};
            in_sync_q <= in_meta_q;
        end
    end

    logic mux_sel_s;
    logic ce_s;
    logic run;
    logic sel_req;
    assign mux_sel_s = in_sync_q[3];
    assign ce_s = in_sync_q[2];
    assign run = !HAS_CE || ce_s;
    // software override, else pin: low picks A, high picks B
    assign sel_req = in_sync_q[1] ? in_sync_q[0] : mux_sel_s;

    // ------------------------------------------------------------------
    // stream capture and switching
    // ------------------------------------------------------------------
    dsm_pkg::dsm_lanes_t in_a_q;
    dsm_pkg::dsm_lanes_t in_b_q;
    logic vs_a_prev_q;
    logic vs_b_prev_q;
    logic cur_q;
    logic pend_q;
    logic aligned_q;
    logic [CW-1:0] retrain_q;
    dsm_pkg::dsm_lanes_t lanes_c_q;

    logic vs_a;
    logic vs_b;
    logic vs_des;
    logic vs_des_prev;
    logic vs_edge;
    logic pending;
    logic switch_now;

    assign vs_a = decode_pix(in_a_q, 0).vs;
    assign vs_b = decode_pix(in_b_q, 0).vs;
    assign pending = sel_req != cur_q;

    always_comb begin
        logic des;
        des = VS_NEW ? sel_req : cur_q;
        vs_des = des ? vs_b : vs_a;
        vs_des_prev = des ? vs_b_prev_q : vs_a_prev_q;
        case (SWITCH_MODE)
            dsm_pkg::SW_VS_START: vs_edge = vs_des && !vs_des_prev;
            dsm_pkg::SW_VS_END: vs_edge = !vs_des && vs_des_prev;
            default: vs_edge = 1'b1;
        endcase
        switch_now = run && pending && vs_edge;
    end

    always_ff @(posedge pix_clk or negedge prst_n_q) begin
        if (!prst_n_q) begin
            in_a_q <= '0;
            in_b_q <= '0;
            vs_a_prev_q <= 1'b0;
            vs_b_prev_q <= 1'b0;
        end else if (run) begin
            in_a_q <= lanes_a;
            in_b_q <= lanes_b;
            vs_a_prev_q <= vs_a;
            vs_b_prev_q <= vs_b;
        end
    end

    always_ff @(posedge pix_clk or negedge prst_n_q) begin
        if (!prst_n_q) begin
            cur_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (run) begin
            if (switch_now) begin
                cur_q <= sel_req;
            end
            pend_q <= pending && !switch_now;
        end
    end

    // one shared PLL must relock to the new stream; output goes dark
    always_ff @(posedge pix_clk or negedge prst_n_q) begin
        if (!prst_n_q) begin
            retrain_q <= '0;
            aligned_q <= 1'b0;
        end else if (run) begin
            if (!TWO_PLLS && switch_now) begin
                retrain_q <= CW'(dsm_pkg::RETRAIN_CYC);
            end else if (retrain_q != '0) begin
                retrain_q <= retrain_q - 1'b1;
            end
            aligned_q <= (retrain_q == '0) && !(!TWO_PLLS && switch_now);
        end
    end

    always_ff @(posedge pix_clk or negedge prst_n_q) begin
        if (!prst_n_q) begin
            lanes_c_q <= '0;
        end else if (run) begin
            if (retrain_q != '0) begin
                lanes_c_q <= '0;
            end else begin
                lanes_c_q <= (cur_q ? in_b_q : in_a_q) & lane_mask();
            end
        end
    end

    assign lanes_c = lanes_c_q;
    assign sel_out = cur_q;
    assign aligned = aligned_q;

    // ------------------------------------------------------------------
    // optional parallel outputs
    // ------------------------------------------------------------------
    dsm_pkg::dsm_lanes_t par_src [dsm_pkg::NUM_STREAMS];
    assign par_src[0] = in_a_q;
    assign par_src[1] = in_b_q;
    assign par_src[2] = lanes_c_q;

    for (genvar s = 0; s < dsm_pkg::NUM_STREAMS; s++) begin : g_par
        for (genvar p = 0; p < 2; p++) begin : g_px
            localparam bit EN = RGB_EN[s] && (p == 0 || PPC2);
            always_ff @(posedge pix_clk or negedge prst_n_q) begin
                if (!prst_n_q) begin
                    par_pix[s][p] <= '0;
                end else if (run) begin
                    par_pix[s][p] <= EN ? decode_pix(par_src[s],
                        p * dsm_pkg::PIX2_LANE_BASE) : '0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // register side: status crossing and APB slave
    // ------------------------------------------------------------------
    logic [2:0] st_meta_q;
    logic [2:0] st_sync_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_word;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_meta_q <= 3'h0;
            st_sync_q <= 3'h0;
        end else begin
            st_meta_q <= {pend_q, aligned_q, cur_q};
            st_sync_q <= st_meta_q;
        end
    end

    always_comb begin
        rd_word = 32'h0;
        case (paddr)
            dsm_pkg::ADDR_CTRL: begin
                rd_word[dsm_pkg::CTRL_OVR_BIT] = ctrl_q.ovr;
                rd_word[dsm_pkg::CTRL_SEL_BIT] = ctrl_q.sel;
            end
            dsm_pkg::ADDR_STATUS: begin
                rd_word[dsm_pkg::STAT_SEL_BIT] = st_sync_q[0];
                rd_word[dsm_pkg::STAT_ALIGN_BIT] = st_sync_q[1];
                rd_word[dsm_pkg::STAT_PEND_BIT] = st_sync_q[2];
            end
            dsm_pkg::ADDR_CONFIG: begin
                rd_word[dsm_pkg::CFG_PPC2_BIT] = PPC2;
                rd_word[dsm_pkg::CFG_DEPTH8_BIT] = DEPTH8;
                rd_word[dsm_pkg::CFG_PLL2_BIT] = TWO_PLLS;
                rd_word[dsm_pkg::CFG_MODE_LSB +: 2] = SWITCH_MODE;
                rd_word[dsm_pkg::CFG_VSNEW_BIT] = VS_NEW;
                rd_word[dsm_pkg::CFG_CE_BIT] = HAS_CE;
                rd_word[dsm_pkg::CFG_RGB_LSB +: 3] = RGB_EN;
            end
            default: rd_word = 32'h0;
        endcase
    end

    // one wait state so that read data and pready leave flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_mapped(paddr);
            prdata_q <= pwrite ? 32'h0 : rd_word;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= dsm_pkg::CTRL_RST;
        end else if (psel && penable && pready_q && pwrite &&
                     paddr == dsm_pkg::ADDR_CTRL) begin
            ctrl_q.ovr <= pwdata[dsm_pkg::CTRL_OVR_BIT];
            ctrl_q.sel <= pwdata[dsm_pkg::CTRL_SEL_BIT];
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_unused_lanes: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        (lanes_c_q & ~lane_mask()) == '0)
        else $error("unused output lane is not quiet");

    a_pixel_two_off: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        !PPC2 |-> par_pix[2][1] == '0 && par_pix[0][1] == '0)
        else $error("second pixel set driven in one pixel build");

    a_depth_mask: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        !DEPTH8 |-> par_pix[2][0].r[7:6] == 2'h0 &&
                    par_pix[2][0].b[7:6] == 2'h0)
        else $error("colour bits above depth are set");

    a_group_off: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        !RGB_EN[0] |-> par_pix[0][0] == '0)
        else $error("disabled parallel group is driven");

    a_imm_follow: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        SWITCH_MODE == dsm_pkg::SW_IMMEDIATE && run && pending
        |=> cur_q == $past(sel_req))
        else $error("immediate switch missed");

    a_vs_instant: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        SWITCH_MODE != dsm_pkg::SW_IMMEDIATE && $changed(cur_q)
        |-> $past(vs_edge) && $past(run))
        else $error("stream changed away from a vsync edge");

    a_retrain_dark: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        !TWO_PLLS && switch_now |=> ##1 lanes_c_q == '0 && !aligned_q)
        else $error("output not blanked during retrain");

    a_ce_freeze: assert property (
        @(posedge pix_clk) disable iff (!prst_n_q)
        !run |=> $stable(cur_q) && $stable(lanes_c_q) && $stable(retrain_q))
        else $error("state moved with clock enable low");

    a_reset_clear: assert property (
        @(posedge pix_clk)
        !prst_n_q |-> cur_q == 1'b0 && lanes_c_q == '0 && retrain_q == '0)
        else $error("state not cleared in reset");

    a_apb_wait: assert property (
        @(posedge mclk) disable iff (!reset_n)
        psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb answer not one wait state");

    c_switch_ab: cover property (
        @(posedge pix_clk) disable iff (!prst_n_q) $rose(cur_q));
    c_switch_ba: cover property (
        @(posedge pix_clk) disable iff (!prst_n_q) $fell(cur_q));
    c_apb_err: cover property (
        @(posedge mclk) disable iff (!reset_n) pready_q && pslverr_q);
endmodule
`default_nettype wire

// File: sim/dsm_src.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// graphics source: 64-pixel frames, vsync high for 8 pixels
// ----------------------------------------------------------------------
module dsm_src #(
    parameter logic [7:0] RED = 8'hA0,
    parameter int VS_AT = 10
) (
    input wire logic pix_clk,
    input wire logic reset_n,
    output dsm_pkg::dsm_lanes_t lanes
);
    logic [5:0] cnt_q;
    logic vs;
    logic hs;

    always_ff @(posedge pix_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    assign vs = (int'(cnt_q) >= VS_AT) && (int'(cnt_q) < VS_AT + 8);
    assign hs = (cnt_q[2:0] == 3'h0);
    // unused lanes toggle every pixel so any leak into lanes_c shows
    // pixel count rides in green, red names the source, blue is ~red
    assign lanes = {~cnt_q, cnt_q, ~cnt_q, cnt_q, cnt_q[3:0], 1'b0,
                    ~vs, vs, hs, RED, 2'h0, cnt_q, ~RED};
endmodule
`default_nettype wire

// File: sim/dsm_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dsm_mux_tb;
    logic mclk;
    logic pix_clk;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mux_sel;
    logic ce;
    dsm_pkg::dsm_lanes_t lanes_a;
    dsm_pkg::dsm_lanes_t lanes_b;
    dsm_pkg::dsm_lanes_t lanes_c;
    logic sel_out;
    logic aligned;
    dsm_pkg::dsm_pix_s par_pix [dsm_pkg::NUM_STREAMS][2];
    // second build: two pixels, 6-bit, one PLL, immediate, clock enable
    logic mux_sel2;
    logic ce2;
    dsm_pkg::dsm_lanes_t lanes_c2;
    logic sel_out2;
    logic aligned2;
    dsm_pkg::dsm_pix_s par_pix2 [dsm_pkg::NUM_STREAMS][2];
    logic [31:0] prdata2;
    logic pready2;
    logic pslverr2;
    int fail_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;
    int n;

    // ------------------------------------------------------------------
    // design and sources
    // ------------------------------------------------------------------
    dsm_mux #(.RGB_EN(3'h7)) i_dsm_mux (
        .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pix_clk(pix_clk),
        .lanes_a(lanes_a), .lanes_b(lanes_b), .mux_sel(mux_sel),
        .ce(ce), .lanes_c(lanes_c), .sel_out(sel_out),
        .aligned(aligned), .par_pix(par_pix)
    );
    dsm_mux #(
        .PIX_PER_CLK(2),
        .COLOR_DEPTH(6),
        .NUM_PLLS(1),
        .SWITCH_MODE(dsm_pkg::SW_IMMEDIATE),
        .HAS_CE(1'b1),
        .RGB_EN(3'h4)
    ) i_dsm_mux_imm (
        .mclk(mclk), .reset_n(reset_n), .psel(1'b0), .penable(1'b0),
        .pwrite(1'b0), .paddr(8'h00), .pwdata(32'h0), .prdata(prdata2),
        .pready(pready2), .pslverr(pslverr2), .pix_clk(pix_clk),
        .lanes_a(lanes_a), .lanes_b(lanes_b), .mux_sel(mux_sel2),
        .ce(ce2), .lanes_c(lanes_c2), .sel_out(sel_out2),
        .aligned(aligned2), .par_pix(par_pix2)
    );
    dsm_src #(.RED(8'hA0), .VS_AT(10)) i_dsm_src_a (
        .pix_clk(pix_clk), .reset_n(reset_n), .lanes(lanes_a)
    );
    dsm_src #(.RED(8'hB0), .VS_AT(40)) i_dsm_src_b (
        .pix_clk(pix_clk), .reset_n(reset_n), .lanes(lanes_b)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // link clock offset by 7 ns; its edges still meet an mclk edge once every 400 ns
    initial begin
        pix_clk = 1'b0;
        #7;
        forever #16 pix_clk = ~pix_clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) chk("pready", 32'h1, 32'h0);
    endtask

    task automatic wait_sel(input logic v, input int lim);
        n = 0;
        while (sel_out !== v && n < lim) begin
            @(posedge pix_clk);
            n++;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk("sel_out", 32'h0, {31'h0, sel_out});
        apb(dsm_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(dsm_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("status", 32'h2, rd);
        apb(8'h0C, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // ppc1, depth8, two plls, start of vsync, new stream, no ce, rgb all
        apb(dsm_pkg::ADDR_CONFIG, 1'b0, 32'h0);
        chk("config", 32'h3AE, rd);
        $display("test reset done");
    endtask

    task automatic t_switch;
        n = 0;
        do begin
            @(posedge pix_clk);
            n++;
        end while (lanes_b[13:8] !== 6'd20 && n < 100);
        mux_sel <= 1'b1;
        // new-stream vsync rises at pixel 40; nothing may move before
        while (lanes_b[13:8] !== 6'd40 && n < 200) begin
            @(posedge pix_clk);
            n++;
            chk("sel_out early", 32'h0, {31'h0, sel_out});
        end
        wait_sel(1'b1, 8);
        chk("sel_out at vsync", 32'h1, {31'h0, sel_out});
        repeat (4) @(posedge pix_clk);
        chk("c red", 32'hB0, {24'h0, lanes_c[23:16]});
        chk("c unused", 32'h0, {4'h0, lanes_c[55:28]});
        chk("aligned", 32'h1, {31'h0, aligned});
        apb(dsm_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("status sel", 32'h1, {31'h0, rd[0]});
        $display("test sync switch done");
    endtask

    task automatic t_override;
        apb(dsm_pkg::ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
        apb(dsm_pkg::ADDR_CTRL, 1'b1, 32'h1);
        wait_sel(1'b0, 150);
        chk("sel_out back", 32'h0, {31'h0, sel_out});
        // stream A vsync spans pixels 10..17 plus capture latency
        chk("a vsync window", 32'h1,
            {31'h0, lanes_a[13:8] >= 6'd10 && lanes_a[13:8] <= 6'd20});
        repeat (4) @(posedge pix_clk);
        chk("c red a", 32'hA0, {24'h0, lanes_c[23:16]});
        chk("par a r", 32'hA0, {24'h0, par_pix[0][0].r});
        chk("par a b", 32'h5F, {24'h0, par_pix[0][0].b});
        chk("par b r", 32'hB0, {24'h0, par_pix[1][0].r});
        chk("par c r", 32'hA0, {24'h0, par_pix[2][0].r});
        chk("par a pix2", 32'h0, {5'h0, par_pix[0][1]});
        apb(dsm_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl back", 32'h1, rd);
        $display("test override done");
    endtask

    // immediate switch in the one-PLL build, first held off by ce low
    task automatic t_immediate;
        @(posedge pix_clk);
        ce2 <= 1'b0;
        mux_sel2 <= 1'b1;
        repeat (8) @(posedge pix_clk);
        chk("frozen sel_out", 32'h0, {31'h0, sel_out2});
        ce2 <= 1'b1;
        n = 0;
        while (sel_out2 !== 1'b1 && n < 8) begin
            @(posedge pix_clk);
            n++;
        end
        chk("imm sel_out", 32'h1, {31'h0, sel_out2});
        repeat (2) @(posedge pix_clk);
        chk("retrain aligned", 32'h0, {31'h0, aligned2});
        chk("retrain c lo", 32'h0, lanes_c2[31:0]);
        chk("retrain c hi", 32'h0, {8'h0, lanes_c2[55:32]});
        n = 0;
        while (aligned2 !== 1'b1 && n < 100) begin
            @(posedge pix_clk);
            n++;
        end
        // 64 dark cycles, counted from a few edges after the switch
        chk("retrain span", 32'h1, {31'h0, n >= 60 && n <= 66});
        repeat (3) @(posedge pix_clk);
        chk("lane 3 off", 32'h0, {25'h0, lanes_c2[27:21]});
        chk("lane 7 off", 32'h0, {25'h0, lanes_c2[55:49]});
        chk("lane 2 b", 32'h10, {27'h0, lanes_c2[20:16]});
        chk("par a off", 32'h0, {5'h0, par_pix2[0][0]});
        chk("par c r top", 32'h0, {30'h0, par_pix2[2][0].r[7:6]});
        $display("test immediate switch done");
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mux_sel = 1'b0;
        ce = 1'b1;
        mux_sel2 = 1'b0;
        ce2 = 1'b0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (10) @(posedge pix_clk);
        t_reset();
        t_switch();
        t_override();
        t_immediate();
        tally_and_finish();
    end

    // whole run is a few hundred link cycles; this is ample margin
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
